// *** design/usm_spi_master.sv ***
// Master-only SPI transfer engine with double-buffered transmit and queued receive
//
// How it works
// (R1) Transfers need the transmitter enabled by software
// (R2) Enabled transmitter drives serial output pin
// (R3) Enabled receiver feeds serial input to shifter
// (R4) Shift clock pin carries master transfer clock
// (R5) Data register write starts every transfer
// (R6) Buffered byte loads when shifter frees up
// (R7) Overflow keeps older bytes, loses a newer one
// (R8) Software reads data once per sent byte
// (R9) Frame, overrun, parity flags read zero
// (R10) Receive flag bit 7 mirrors unread data
// (R11) Transmit complete bit 6, clear by one/ack
// (R12) Empty flag bit 5, set after reset
// (R13) Receive irq needs enable bit 7, global
// (R14) Transmit irq needs enable bit 6, global
// (R15) Empty irq needs enable bit 5, global
// (R16) Software writes zero to status bits 4:0
// (R17) Receiver disable flushes receive buffer
// (R18) Receiver alone never makes transfers
// (R19) Master only, no slave select
// (R20) One transmit holding byte, two-deep receive queue
// (R21) No collision flag, no double speed
// (R22) Both mode-select bits one enable SPI
// (R23) Polarity and phase pick four modes
// (R24) Eight-bit frames, selectable bit order
// (R25) Clock equals clk over 2(divisor+1)
// (R26) Idle shift clock rests at polarity level
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "usm_defs.svh"

module usm_spi_master (
    input wire logic clk, // 40 MHz system clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [`USM_ADDR_W-1:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic global_irq_enable, // Global interrupt flag of cpu_status_word
    input wire logic tx_complete_irq_ack, // Pulse when transmit irq is serviced
    output usm_pkg::usm_irq_s irq_req, // Interrupt requests
    output logic serial_out_pin_o, // Serial data out
    output logic serial_out_pin_oe, // High while transmitter owns the pin
    input wire logic serial_in_pin_i, // Serial data in, asynchronous
    output logic shift_clock_pin_o, // Shift clock out
    output logic shift_clock_pin_oe, // High while master drives clock
    output logic receiver_owns_in_pin // High while receiver overrides port
);

    // Register contents
    usm_pkg::usm_ctrl_s ctrl;
    usm_pkg::usm_mode_s mode;
    logic [11:0] baud_divisor;

    // Transmit side
    logic tx_buf_valid;
    logic [7:0] tx_buf;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    usm_pkg::usm_state_e state;
    logic [3:0] edge_cnt;
    logic [11:0] baud_cnt;
    logic frame_done;
    logic transmit_complete_flag;

    // Receive side
    logic [7:0] rx_mem [0:`USM_RX_DEPTH-1];
    logic rx_wr_ptr;
    logic rx_rd_ptr;
    logic [1:0] rx_count;
    logic rx_pend_valid;
    logic [7:0] rx_pend;

    // Input synchroniser
    logic sin_meta;
    logic sin_sync;

    // Decoded strobes and conditions
    logic wr_data;
    logic wr_status;
    logic rd_data;
    logic spi_mode;
    logic tx_active;
    logic can_load;
    logic tick;
    logic is_lead;
    logic sample_edge;
    logic receive_complete_flag;
    logic tx_buffer_empty_flag;
    logic rx_pop;
    logic rx_incoming;
    logic rx_space;
    logic rx_push;
    logic [7:0] rx_push_data;

    // Bit that leaves first under the chosen order
    function automatic logic pick_bit(input logic [7:0] s, input logic lsb_first);
        pick_bit = lsb_first ? s[0] : s[7];
    endfunction

    // Move the next bit into the output position
    function automatic logic [7:0] shift_out(input logic [7:0] s, input logic lsb_first);
        shift_out = lsb_first ? {1'b0, s[7:1]} : {s[6:0], 1'b0};
    endfunction

    assign wr_data = reg_wr && (reg_addr == `USM_OFS_DATA);
    assign wr_status = reg_wr && (reg_addr == `USM_OFS_STATUS);
    assign rd_data = reg_rd && (reg_addr == `USM_OFS_DATA);
    assign spi_mode = (mode.port_mode_select == `USM_MODE_SPI); // R22

    // Disable takes effect only once queued and shifting data are gone
    assign tx_active = ctrl.transmitter_enable || tx_buf_valid || (state == usm_pkg::USM_SHIFT);
    assign can_load = (state == usm_pkg::USM_IDLE) && tx_buf_valid && spi_mode; // R6
    assign tx_buffer_empty_flag = !tx_buf_valid; // R12
    assign receive_complete_flag = (rx_count != 2'h0); // R10

    // Half-period tick; divider runs only inside a frame so idle has no edges
    assign tick = (state == usm_pkg::USM_SHIFT) && (baud_cnt == baud_divisor); // R25 R26
    assign is_lead = !edge_cnt[0];
    assign sample_edge = mode.clock_phase_bit ? !is_lead : is_lead; // R23

    // Serial input passes two flops before use
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sin_meta <= 1'b0;
            sin_sync <= 1'b0;
        end
        else
        begin
            sin_meta <= serial_in_pin_i;
            sin_sync <= sin_meta;
        end
    end

    // Control, mode and divisor registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl <= `USM_CONTROL_RESET;
            mode <= `USM_MODE_RESET;
            baud_divisor <= `USM_BAUD_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `USM_OFS_CONTROL: ctrl <= {reg_wdata[7:3], 3'h0};
                `USM_OFS_MODE: mode <= {reg_wdata[7:6], 3'h0, reg_wdata[2:0]};
                `USM_OFS_BAUD_LO: baud_divisor[7:0] <= reg_wdata;
                `USM_OFS_BAUD_HI: baud_divisor[11:8] <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // Transmit holding byte; writes while full or disabled are dropped
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_buf_valid <= 1'b0;
            tx_buf <= 8'h00;
        end
        else if (wr_data && !tx_buf_valid && ctrl.transmitter_enable) // R1 R5 R18 R20
        begin
            tx_buf_valid <= 1'b1;
            tx_buf <= reg_wdata;
        end
        else if (can_load)
        begin
            tx_buf_valid <= 1'b0; // R6
        end
    end

    // Half-period divider
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            baud_cnt <= 12'h000;
        else if (state == usm_pkg::USM_IDLE || tick)
            baud_cnt <= 12'h000;
        else
            baud_cnt <= baud_cnt + 12'h001; // R25
    end

    // Frame shifter: eight bits, sixteen clock edges
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= usm_pkg::USM_IDLE;
            edge_cnt <= 4'h0;
            tx_shift <= 8'h00;
            rx_shift <= 8'h00;
            serial_out_pin_o <= 1'b1;
            shift_clock_pin_o <= 1'b0;
            frame_done <= 1'b0;
        end
        else
        begin
            frame_done <= 1'b0;
            case (state)
                usm_pkg::USM_IDLE:
                begin
                    shift_clock_pin_o <= mode.clock_polarity_bit; // R26
                    if (can_load)
                    begin
                        state <= usm_pkg::USM_SHIFT;
                        edge_cnt <= 4'h0;
                        tx_shift <= tx_buf;
                        serial_out_pin_o <= pick_bit(tx_buf, mode.bit_order_select); // R24
                    end
                end
                usm_pkg::USM_SHIFT:
                begin
                    if (tick)
                    begin
                        shift_clock_pin_o <= !shift_clock_pin_o; // R4 R23
                        edge_cnt <= edge_cnt + 4'h1;
                        if (sample_edge)
                        begin
                            // Receiver shares the transmitter's order
                            rx_shift <= mode.bit_order_select ? {sin_sync, rx_shift[7:1]}
                                                              : {rx_shift[6:0], sin_sync}; // R24
                        end
                        else if (!(mode.clock_phase_bit && edge_cnt == 4'h0))
                        begin
                            // First leading edge in phase 1 keeps the bit set at load
                            tx_shift <= shift_out(tx_shift, mode.bit_order_select);
                            serial_out_pin_o <= pick_bit(shift_out(tx_shift,
                                mode.bit_order_select), mode.bit_order_select); // R23
                        end
                        if (edge_cnt == `USM_FRAME_LAST)
                        begin
                            state <= usm_pkg::USM_IDLE;
                            frame_done <= 1'b1;
                        end
                    end
                end
                default: state <= usm_pkg::USM_IDLE;
            endcase
        end
    end

    // Transmit complete: hardware set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            transmit_complete_flag <= 1'b0;
        else if (frame_done && !tx_buf_valid)
            transmit_complete_flag <= 1'b1; // R11
        else if (tx_complete_irq_ack || (wr_status && reg_wdata[`USM_ST_TXC]))
            transmit_complete_flag <= 1'b0; // R11
    end

    // Receive queue: two entries plus one overwriteable pending byte
    assign rx_pop = rd_data && receive_complete_flag;
    assign rx_incoming = frame_done && ctrl.receiver_enable; // R3
    assign rx_space = (rx_count != 2'(`USM_RX_DEPTH)) || rx_pop;
    assign rx_push = rx_space && (rx_pend_valid || rx_incoming);
    assign rx_push_data = rx_pend_valid ? rx_pend : rx_shift;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_wr_ptr <= 1'b0;
            rx_rd_ptr <= 1'b0;
            rx_count <= 2'h0;
            rx_pend_valid <= 1'b0;
            rx_pend <= 8'h00;
        end
        else if (!ctrl.receiver_enable)
        begin
            // Disabling throws away every unread byte
            rx_wr_ptr <= 1'b0;
            rx_rd_ptr <= 1'b0;
            rx_count <= 2'h0;
            rx_pend_valid <= 1'b0; // R17
        end
        else
        begin
            if (rx_push)
            begin
                rx_mem[rx_wr_ptr] <= rx_push_data;
                rx_wr_ptr <= !rx_wr_ptr;
            end
            if (rx_pop)
                rx_rd_ptr <= !rx_rd_ptr;
            rx_count <= rx_count + {1'b0, rx_push} - {1'b0, rx_pop};
            // Pending stage: a later frame replaces a byte still waiting here
            if (rx_incoming && (rx_pend_valid || !rx_space))
            begin
                rx_pend_valid <= 1'b1;
                rx_pend <= rx_shift; // R7
            end
            else if (rx_push && rx_pend_valid)
            begin
                rx_pend_valid <= 1'b0;
            end
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `USM_OFS_DATA: reg_rdata <= receive_complete_flag ? rx_mem[rx_rd_ptr] : 8'h00;
                // Error bits and reserved bits always zero
                `USM_OFS_STATUS: reg_rdata <= {receive_complete_flag, transmit_complete_flag,
                                               tx_buffer_empty_flag, 5'h00}; // R9 R10 R12 R21
                `USM_OFS_CONTROL: reg_rdata <= ctrl;
                `USM_OFS_MODE: reg_rdata <= mode;
                `USM_OFS_BAUD_LO: reg_rdata <= baud_divisor[7:0];
                `USM_OFS_BAUD_HI: reg_rdata <= {4'h0, baud_divisor[11:8]};
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // Interrupt requests and pin ownership, all registered
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_req <= '0;
            serial_out_pin_oe <= 1'b0;
            shift_clock_pin_oe <= 1'b0;
            receiver_owns_in_pin <= 1'b0;
        end
        else
        begin
            irq_req.rx_complete <= ctrl.rx_complete_irq_enable && global_irq_enable
                                   && receive_complete_flag; // R13
            irq_req.tx_complete <= ctrl.tx_complete_irq_enable && global_irq_enable
                                   && transmit_complete_flag; // R14
            irq_req.tx_empty <= ctrl.tx_empty_irq_enable && global_irq_enable
                                && tx_buffer_empty_flag; // R15
            serial_out_pin_oe <= tx_active; // R2
            shift_clock_pin_oe <= tx_active && spi_mode; // R4 R19
            receiver_owns_in_pin <= ctrl.receiver_enable; // R3
        end
    end

endmodule

`default_nettype wire

// *** design/usm_defs.svh ***
// Register offsets, field positions, reset values and sizes of the SPI master block
`ifndef USM_DEFS_SVH
`define USM_DEFS_SVH

`define USM_ADDR_W 3
`define USM_OFS_DATA 3'h0
`define USM_OFS_STATUS 3'h1
`define USM_OFS_CONTROL 3'h2
`define USM_OFS_MODE 3'h3
`define USM_OFS_BAUD_LO 3'h4
`define USM_OFS_BAUD_HI 3'h5

`define USM_ST_RXC 7
`define USM_ST_TXC 6
`define USM_ST_UDRE 5

`define USM_CT_RXCIE 7
`define USM_CT_TXCIE 6
`define USM_CT_TX_EMPTY_IRQ_ENABLE 5
`define USM_CT_RXEN 4
`define USM_CT_TXEN 3

`define USM_CONTROL_RESET 8'h00
`define USM_MODE_RESET 8'h06
`define USM_MODE_SPI 2'h3
`define USM_BAUD_RESET 12'h000
`define USM_FRAME_LAST 4'hf
`define USM_RX_DEPTH 2

`endif

// *** design/usm_pkg.sv ***
// Types shared by the SPI master block
`default_nettype none
package usm_pkg;

    // Shifter state
    typedef enum logic [0:0] {
        USM_IDLE = 1'b0,
        USM_SHIFT = 1'b1
    } usm_state_e;

    // Mode configuration register layout
    typedef struct packed {
        logic [1:0] port_mode_select;
        logic [2:0] reserved;
        logic bit_order_select;
        logic clock_phase_bit;
        logic clock_polarity_bit;
    } usm_mode_s;

    // Control enables register layout
    typedef struct packed {
        logic rx_complete_irq_enable;
        logic tx_complete_irq_enable;
        logic tx_empty_irq_enable;
        logic receiver_enable;
        logic transmitter_enable;
        logic [2:0] reserved;
    } usm_ctrl_s;

    // Interrupt requests travel together
    typedef struct packed {
        logic rx_complete;
        logic tx_complete;
        logic tx_empty;
    } usm_irq_s;

endpackage

`default_nettype wire

// *** verification/usm_slave_model.sv ***
// Behavioural SPI slave for modes 0 and 3 that echoes the previous frame
`timescale 1ns/100ps
`default_nettype none
module usm_slave_model (
    input wire logic sck, // Shift clock
    input wire logic mosi, // Data in
    output logic miso, // Data out
    output logic [7:0] got // Last byte in
);
    // Sample on rising, launch on falling; fits both modes whose phase equals polarity
    always @(posedge sck)
        got <= {got[6:0], mosi};
    // The fall that leaves reset only reloads the bit already shown
    always @(negedge sck)
        miso <= got[7];
    initial
    begin
        got = 8'h3c;
        miso = 1'b0;
    end
endmodule
`default_nettype wire

// *** verification/usm_spi_master_monitor.sv ***
// Port assertions for the SPI master block
`timescale 1ns/100ps
`default_nettype none
module usm_spi_master_monitor (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic [2:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write
    input wire logic reg_rd, // Read
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic global_irq_enable, // Global
    input wire logic tx_complete_irq_ack, // Ack
    input wire usm_pkg::usm_irq_s irq_req, // Irqs
    input wire logic serial_out_pin_o, // Out
    input wire logic serial_out_pin_oe, // Out enable
    input wire logic serial_in_pin_i, // In
    input wire logic shift_clock_pin_o, // Clock
    input wire logic shift_clock_pin_oe, // Clock enable
    input wire logic receiver_owns_in_pin // Rx owns pin
);
    logic [7:0] ctl;
    logic pol;
    logic [11:0] div;
    logic [15:0] gap;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Shadow of settings, written on the same edge as the block's own
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl <= 8'h00;
            pol <= 1'b0;
            div <= 12'h000;
        end
        else if (reg_wr && reg_addr == 3'h2)
            ctl <= reg_wdata;
        else if (reg_wr && reg_addr == 3'h3)
            pol <= reg_wdata[0];
        else if (reg_wr && reg_addr == 3'h4)
            div[7:0] <= reg_wdata;
        else if (reg_wr && reg_addr == 3'h5)
            div[11:8] <= reg_wdata[3:0];
    end
    // Cycles since the shift clock moved, saturating
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            gap <= 16'h0000;
        else if ($changed(shift_clock_pin_o))
            gap <= 16'h0000;
        else if (gap != 16'hffff)
            gap <= gap + 16'h0001;
    end
    AST_TX_PIN: assert property ($rose(ctl[3]) |-> ##[0:2] serial_out_pin_oe)
        else $error("serial out not taken over");
    AST_RX_PIN: assert property ($changed(ctl[4]) |-> ##[1:2] receiver_owns_in_pin == ctl[4])
        else $error("serial in ownership wrong");
    AST_SCK_SPACE: assert property ($changed(shift_clock_pin_o) |-> gap >= {4'h0, div})
        else $error("shift clock too fast");
    AST_SCK_EXACT: assert property ($past(shift_clock_pin_o) != pol && gap == {4'h0, div}
        |-> $changed(shift_clock_pin_o))
        else $error("shift clock half period wrong");
    AST_SCK_IDLE: assert property (!serial_out_pin_oe |-> shift_clock_pin_o == pol)
        else $error("idle shift clock level wrong");
    AST_STATUS_LOW: assert property (reg_rd && reg_addr == 3'h1 |=> reg_rdata[4:0] == 5'h00)
        else $error("unused status bits not zero");
    AST_IRQ_RX: assert property (irq_req.rx_complete |-> $past(global_irq_enable) && $past(ctl[7]))
        else $error("receive irq without enables");
    AST_IRQ_TX: assert property (irq_req.tx_complete |-> $past(global_irq_enable) && $past(ctl[6]))
        else $error("transmit irq without enables");
    AST_IRQ_TXE: assert property (irq_req.tx_empty |-> $past(global_irq_enable) && $past(ctl[5]))
        else $error("empty irq without enables");
    // Main scenarios reached
    COV_FRAME: cover property ($rose(shift_clock_pin_o));
    COV_TXC: cover property ($rose(irq_req.tx_complete));
    COV_RXC: cover property ($rose(irq_req.rx_complete));
endmodule
bind usm_spi_master usm_spi_master_monitor u_mon (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_irq_enable(global_irq_enable), .tx_complete_irq_ack(tx_complete_irq_ack),
    .irq_req(irq_req), .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe),
    .serial_in_pin_i(serial_in_pin_i), .shift_clock_pin_o(shift_clock_pin_o),
    .shift_clock_pin_oe(shift_clock_pin_oe), .receiver_owns_in_pin(receiver_owns_in_pin));
`default_nettype wire

// *** verification/test_usm_spi_master.sv ***
// Self-checking bench for the SPI master block
`timescale 1ns/100ps
`default_nettype none
module test_usm_spi_master;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] ad = 3'h0;
    logic [7:0] wd = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic gie = 1'b0;
    logic ack = 1'b0;
    logic [7:0] rdata, got, d, prev;
    usm_pkg::usm_irq_s irq;
    logic sout, sout_oe, sin, sck, sck_oe, rx_own;
    int n_errors = 0;
    int tests_run = 0;
    int n_sck = 0;
    int cyc = 0;
    usm_spi_master DUT (.clk(clk), .rst_b(rst_b), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr_s),
        .reg_rd(rd_s), .reg_rdata(rdata), .global_irq_enable(gie), .tx_complete_irq_ack(ack),
        .irq_req(irq), .serial_out_pin_o(sout), .serial_out_pin_oe(sout_oe),
        .serial_in_pin_i(sin), .shift_clock_pin_o(sck), .shift_clock_pin_oe(sck_oe),
        .receiver_owns_in_pin(rx_own));
    usm_slave_model u_slave (.sck(sck), .mosi(sout), .miso(sin), .got(got));
    // Clock, edge count and hang guard
    initial forever #12.5 clk = ~clk;
    always @(posedge sck) n_sck++;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        tests_run++;
        if (a !== e)
        begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, a, e);
        end
    endtask
    // Strobes drop one edge later, so back-to-back calls leave a gap
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        ad <= a;
        wd <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        ad <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic xfer(input logic [7:0] b);
        d = 8'h00;
        while (d[5] !== 1'b1)
            rd(3'h1);
        wr(3'h0, b);
    endtask
    task automatic wait_txc();
        int i;
        i = 0;
        d = 8'h00;
        while (d[6] !== 1'b1 && i < 400)
        begin
            rd(3'h1);
            i++;
        end
        chk(d & 8'h40, 8'h40);
    endtask
    task automatic t_reset();
        rd(3'h1);
        chk(d, 8'h20);
        rd(3'h2);
        chk(d, 8'h00);
        rd(3'h3);
        chk(d, 8'h06);
        rd(3'h6);
        chk(d, 8'h00);
        $display("reset values done");
    endtask
    // Receiver alone, then a byte held while the mode select is not SPI
    task automatic t_rx_only();
        wr(3'h2, 8'h10);
        wr(3'h0, 8'h77);
        rd(3'h1);
        chk(d, 8'h20);
        chk({7'h0, rx_own}, 8'h01);
        wr(3'h2, 8'h18);
        wr(3'h0, 8'h77);
        repeat (60) @(posedge clk);
        chk(8'(n_sck), 8'h00);
        rd(3'h1);
        chk(d, 8'h00);
        chk({6'h0, sout_oe, sck_oe}, 8'h02);
        // Selecting SPI releases the held byte; it brings back the slave's first byte
        wr(3'h3, 8'hc0);
        wait_txc();
        rd(3'h0);
        chk(d, 8'h3c);
        wr(3'h1, 8'h40);
        $display("receiver only done");
    endtask
    task automatic t_frame(input logic [7:0] m, input logic [7:0] b, input logic [7:0] e);
        int n0;
        wr(3'h3, m);
        // A polarity change moves the idle clock once; let the slave settle first
        repeat (2) @(posedge clk);
        prev = got;
        n0 = n_sck;
        xfer(b);
        wait_txc();
        chk(8'(n_sck - n0), 8'h08);
        chk(got, e);
        chk({6'h0, sout_oe, sck_oe}, 8'h03);
        chk({7'h0, sck}, {7'h0, m[0]});
        rd(3'h1);
        chk(d, 8'he0);
        rd(3'h0);
        chk(d, prev);
        wr(3'h1, 8'h40);
        rd(3'h1);
        chk(d, 8'h20);
        $display("frame done");
    endtask
    task automatic t_overflow();
        prev = got;
        xfer(8'h11);
        xfer(8'h22);
        xfer(8'h33);
        xfer(8'h44);
        wait_txc();
        repeat (4) @(posedge clk);
        rd(3'h0);
        chk(d, prev);
        rd(3'h0);
        chk(d, 8'h11);
        rd(3'h1);
        rd(3'h0);
        chk(d, 8'h33);
        rd(3'h1);
        chk(d, 8'h60);
        wr(3'h1, 8'h40);
        $display("overflow done");
    endtask
    task automatic t_irq();
        gie <= 1'b1;
        wr(3'h2, 8'hf8);
        repeat (3) @(posedge clk);
        chk({5'h0, irq}, 8'h01);
        xfer(8'h5e);
        wait_txc();
        repeat (3) @(posedge clk);
        chk({5'h0, irq}, 8'h07);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (3) @(posedge clk);
        chk({5'h0, irq}, 8'h05);
        gie <= 1'b0;
        repeat (3) @(posedge clk);
        chk({5'h0, irq}, 8'h00);
        wr(3'h2, 8'h18);
        rd(3'h0);
        $display("interrupts done");
    endtask
    task automatic t_flush();
        xfer(8'h3a);
        wait_txc();
        wr(3'h2, 8'h08);
        rd(3'h1);
        chk(d, 8'h60);
        chk({7'h0, rx_own}, 8'h00);
        wr(3'h2, 8'h18);
        rd(3'h0);
        chk(d, 8'h00);
        $display("flush done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence; divisor 7 keeps the slave bit settled before sampling
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        wr(3'h4, 8'h07);
        t_rx_only();
        wr(3'h2, 8'h18);
        t_frame(8'hc0, 8'ha5, 8'ha5);
        t_frame(8'hc3, 8'h5a, 8'h5a);
        t_frame(8'hc4, 8'h01, 8'h80);
        wr(3'h3, 8'hc0);
        t_overflow();
        t_irq();
        t_flush();
        complete_run();
    end
endmodule
`default_nettype wire
